// ### rtl/sirr_regs.vh
// Register indices, field positions, reset values and timing for the ingress register group
`ifndef SIRR_REGS_VH
`define SIRR_REGS_VH

// Register indices; byte address is four times the index
`define SIRR_IDX_RATE_CMD        16'h184b
`define SIRR_IDX_OP_STATUS       16'h184c
`define SIRR_IDX_WRITE_VALUE     16'h184d
`define SIRR_IDX_READ_VALUE      16'h184e
`define SIRR_IDX_PORT0_DROPPED   16'h1850
`define SIRR_IDX_PORT1_DROPPED   16'h1851
`define SIRR_IDX_PORT2_DROPPED   16'h1852
`define SIRR_IDX_PORT0_REMAP     16'h1855

// Command register fields
`define SIRR_CMD_DIR_BIT         7
`define SIRR_CMD_TYPE_HI         6
`define SIRR_CMD_TYPE_LO         5
`define SIRR_CMD_INDEX_HI        4
`define SIRR_CMD_INDEX_LO        0
`define SIRR_CMD_WIDTH           8
`define SIRR_DIR_READ            1'b1
`define SIRR_DIR_WRITE           1'b0

// Entry type encodings
`define SIRR_TYPE_RESERVED       2'h0
`define SIRR_TYPE_CIR            2'h1
`define SIRR_TYPE_CBS            2'h2
`define SIRR_TYPE_EBS            2'h3

// Field positions
`define SIRR_PENDING_BIT         0
`define SIRR_TABLE_DATA_WIDTH    16
`define SIRR_REMAP_WIDTH         24
`define SIRR_REMAP_FIELD_WIDTH   3

// Table layout and reset values
`define SIRR_CIR_ENTRIES         24
`define SIRR_TABLE_DEPTH         26
`define SIRR_TABLE_ADDR_WIDTH    5
`define SIRR_ADDR_CBS            5'h18
`define SIRR_ADDR_EBS            5'h19
`define SIRR_RST_CIR             16'h0014
`define SIRR_RST_BURST           16'h0600
`define SIRR_RST_WRITE_VALUE     16'h0000
`define SIRR_RST_READ_VALUE      16'h0000
`define SIRR_RST_COUNT           32'h00000000
`define SIRR_COUNT_MAX           32'hffffffff
`define SIRR_RST_REMAP           24'hfac688
`define SIRR_RST_CMD             8'h00

// Committed rate time step per byte, in ns
`define SIRR_CIR_STEP_NS         20

// AXI responses
`define SIRR_RESP_OKAY           2'h0
`define SIRR_RESP_SLVERR         2'h2

`endif

// ### rtl/sirr_rate_table.v
// Rate metering table memory: one write port, two registered read ports
`timescale 1ns/1ps
`include "sirr_regs.vh"

module sirr_rate_table #(
  parameter DEPTH = `SIRR_TABLE_DEPTH,
  parameter AW    = `SIRR_TABLE_ADDR_WIDTH,
  parameter DW    = `SIRR_TABLE_DATA_WIDTH
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          reset_n,
  // Software access port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data,
  // Meter lookup port
  input  wire [AW-1:0] meter_addr,
  output reg  [DW-1:0] meter_data
);

  reg [DW-1:0] mem [0:DEPTH-1];
  integer i;

  // Entries start at documented defaults so metering works before setup
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (i < `SIRR_CIR_ENTRIES) begin
          mem[i] <= `SIRR_RST_CIR;
        end else begin
          mem[i] <= `SIRR_RST_BURST;
        end
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered reads; out-of-range addresses read zero
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data    <= {DW{1'b0}};
      meter_data <= {DW{1'b0}};
    end else begin
      rd_data    <= (rd_addr < DEPTH) ? mem[rd_addr] : {DW{1'b0}};
      meter_data <= (meter_addr < DEPTH) ? mem[meter_addr] : {DW{1'b0}};
    end
  end

endmodule // sirr_rate_table

// ### rtl/sirr_top.v
// Ingress rate table access, filtered packet counters and port 0 priority remap
// Summary of operation
// - Pending flag high during table operation
// - Write holding value stored into selected entry
// - Read entry lands in read holding register
// - Three per-port 32-bit filtered drop counters
// - Rate limit drops are never counted here
// - Reading a counter clears it
// - Counters saturate at all ones
// - Port 0 priority n maps via field n
// - Regenerated priority picks the output queue
// - Remap fields reset to identity mapping
// - Direction bit 7: one reads, zero writes
// - Bits 6:5 select entry type
// - Bits 4:0 pick one of 24 rate entries
// - Rate entry means (value+1) times 20 ns
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sirr_regs.vh"

module sirr_top #(
  parameter NPORTS = 3,
  parameter AW     = 16
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              reset_n,
  // AXI4-Lite write address
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [AW-1:0]     s_axi_awaddr,
  // AXI4-Lite write data
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  output reg  [1:0]        s_axi_bresp,
  // AXI4-Lite read address
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  input  wire [AW-1:0]     s_axi_araddr,
  // AXI4-Lite read data
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  // Ingress drop events, one-cycle pulses per port
  input  wire [NPORTS-1:0] drop_valid,
  input  wire [NPORTS-1:0] drop_by_rate_limit,
  // Port 0 received frame priority
  input  wire              rx_frame_valid,
  input  wire [2:0]        rx_priority,
  // Regenerated priority and output queue
  output reg               queue_valid,
  output reg  [2:0]        regen_priority,
  output reg  [1:0]        queue_select,
  // Meter lookup of committed rate time per byte
  input  wire [4:0]        meter_index,
  output reg  [21:0]       meter_byte_time_ns
);

  localparam TDW = `SIRR_TABLE_DATA_WIDTH;
  localparam TAW = `SIRR_TABLE_ADDR_WIDTH;

  // Operation sequencer states
  localparam ST_IDLE  = 2'd0;
  localparam ST_ISSUE = 2'd1;
  localparam ST_WAIT  = 2'd2;

  // Maps command type and index to a table address
  function [TAW-1:0] entry_addr;
    input [1:0] etype;
    input [4:0] idx;
    begin
      case (etype)
        `SIRR_TYPE_CIR: entry_addr = idx;
        `SIRR_TYPE_CBS: entry_addr = `SIRR_ADDR_CBS;
        default:        entry_addr = `SIRR_ADDR_EBS;
      endcase
    end
  endfunction

  // Only committed rate entries in range and burst types are real targets
  function entry_ok;
    input [1:0] etype;
    input [4:0] idx;
    begin
      case (etype)
        `SIRR_TYPE_RESERVED: entry_ok = 1'b0;
        `SIRR_TYPE_CIR:      entry_ok = (idx < `SIRR_CIR_ENTRIES);
        default:             entry_ok = 1'b1;
      endcase
    end
  endfunction

  // Word index of a byte address
  function [AW-3:0] word_of;
    input [AW-1:0] a;
    begin
      word_of = a[AW-1:2];
    end
  endfunction

  // Byte-enable merge of a write into a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // Software visible state
  reg [`SIRR_CMD_WIDTH-1:0] rate_table_command;
  reg                       op_pending;
  reg [TDW-1:0]             rate_table_write_value;
  reg [TDW-1:0]             rate_table_read_value;
  reg [`SIRR_REMAP_WIDTH-1:0] port0_priority_remap;
  reg [31:0]                dropped_count [0:NPORTS-1];
  reg [1:0]                 op_state;

  // Write channel holding
  reg          aw_held;
  reg [AW-1:0] aw_addr_q;
  reg          w_held;
  reg [31:0]   w_data_q;
  reg [3:0]    w_strb_q;

  // Table port wiring
  wire           tbl_wr_en;
  wire [TAW-1:0] tbl_addr;
  wire [TDW-1:0] tbl_rd_data;
  wire [TDW-1:0] meter_data;

  // Command fields
  wire       cmd_dir   = rate_table_command[`SIRR_CMD_DIR_BIT];
  wire [1:0] cmd_type  = rate_table_command[`SIRR_CMD_TYPE_HI:`SIRR_CMD_TYPE_LO];
  wire [4:0] cmd_index = rate_table_command[`SIRR_CMD_INDEX_HI:`SIRR_CMD_INDEX_LO];
  wire       cmd_ok    = entry_ok(cmd_type, cmd_index);

  // Write channel handshakes; each side is taken once and held until the response
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire       wr_go    = aw_held && w_held && !s_axi_bvalid;
  wire [AW-3:0] wr_word = word_of(aw_addr_q);

  // Read channel accepts a new address only when no answer is waiting
  assign s_axi_arready = !s_axi_rvalid;
  wire       rd_go   = s_axi_arvalid && s_axi_arready;
  wire [AW-3:0] rd_word = word_of(s_axi_araddr);

  // Address decode of the write target
  wire wr_cmd   = wr_go && (wr_word == `SIRR_IDX_RATE_CMD);
  wire wr_wval  = wr_go && (wr_word == `SIRR_IDX_WRITE_VALUE);
  wire wr_remap = wr_go && (wr_word == `SIRR_IDX_PORT0_REMAP);
  // Held write merged lane by lane; a new command must replace, never OR into, the old one
  wire [31:0] cmd_word   = merge({24'h000000, rate_table_command}, w_data_q, w_strb_q);
  wire [31:0] wval_word  = merge({16'h0000, rate_table_write_value}, w_data_q, w_strb_q);
  wire [31:0] remap_word = merge({8'h00, port0_priority_remap}, w_data_q, w_strb_q);

  // Capture write address and data independently
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held   <= 1'b0;
      aw_addr_q <= {AW{1'b0}};
      w_held    <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only targets get SLVERR
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SIRR_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_cmd || wr_wval || wr_remap) ? `SIRR_RESP_OKAY : `SIRR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software writable registers; a command write while busy is dropped
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rate_table_command     <= `SIRR_RST_CMD;
      rate_table_write_value <= `SIRR_RST_WRITE_VALUE;
      port0_priority_remap   <= `SIRR_RST_REMAP;
    end else begin
      if (wr_cmd && !op_pending) begin
        rate_table_command <= cmd_word[`SIRR_CMD_WIDTH-1:0];
      end
      if (wr_wval) begin
        rate_table_write_value <= wval_word[TDW-1:0];
      end
      if (wr_remap) begin
        port0_priority_remap <= remap_word[`SIRR_REMAP_WIDTH-1:0];
      end
    end
  end

  // Table operation sequencer: a command write starts it, pending tracks it
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      op_state              <= ST_IDLE;
      op_pending            <= 1'b0;
      rate_table_read_value <= `SIRR_RST_READ_VALUE;
    end else begin
      case (op_state)
        ST_IDLE: begin
          if (wr_cmd && !op_pending) begin
            op_state   <= ST_ISSUE;
            op_pending <= 1'b1;
          end
        end
        ST_ISSUE: begin
          if (cmd_dir == `SIRR_DIR_READ) begin
            op_state <= ST_WAIT;
          end else begin
            op_state   <= ST_IDLE;
            op_pending <= 1'b0;
          end
        end
        ST_WAIT: begin
          // Reserved or out-of-range targets read back zero
          rate_table_read_value <= cmd_ok ? tbl_rd_data : {TDW{1'b0}};
          op_state              <= ST_IDLE;
          op_pending            <= 1'b0;
        end
        default: begin
          op_state   <= ST_IDLE;
          op_pending <= 1'b0;
        end
      endcase
    end
  end

  // Table write only in the issue cycle of a valid write command
  assign tbl_wr_en = (op_state == ST_ISSUE) && (cmd_dir == `SIRR_DIR_WRITE) && cmd_ok;
  assign tbl_addr  = entry_addr(cmd_type, cmd_index);

  sirr_rate_table #(
    .DEPTH (`SIRR_TABLE_DEPTH),
    .AW    (TAW),
    .DW    (TDW)
  ) u_table (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .wr_en      (tbl_wr_en),
    .wr_addr    (tbl_addr),
    .wr_data    (rate_table_write_value),
    .rd_addr    (tbl_addr),
    .rd_data    (tbl_rd_data),
    .meter_addr (meter_index),
    .meter_data (meter_data)
  );

  // Full-width product; the largest entry still fits in 22 bits
  wire [31:0] byte_time_full = ({16'h0000, meter_data} + 32'h00000001) * `SIRR_CIR_STEP_NS;

  // Time per byte for the meter; lookup adds one cycle, this stage one more
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meter_byte_time_ns <= 22'h0;
    end else begin
      meter_byte_time_ns <= byte_time_full[21:0];
    end
  end

  // Per-port counters; a read clears, a drop in the same cycle still counts one
  genvar p;
  generate
    for (p = 0; p < NPORTS; p = p + 1) begin : g_cnt
      wire hit   = drop_valid[p] && !drop_by_rate_limit[p];
      wire clear = rd_go && (rd_word == (`SIRR_IDX_PORT0_DROPPED + p));
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          dropped_count[p] <= `SIRR_RST_COUNT;
        end else if (clear) begin
          dropped_count[p] <= hit ? 32'h00000001 : `SIRR_RST_COUNT;
        end else if (hit && (dropped_count[p] != `SIRR_COUNT_MAX)) begin
          dropped_count[p] <= dropped_count[p] + 32'h00000001;
        end
      end
    end
  endgenerate

  // Read data mux; unmapped addresses answer SLVERR with zero data
  reg [31:0] next_rdata;
  reg        next_rerr;
  always @* begin
    next_rdata = 32'h00000000;
    next_rerr  = 1'b0;
    case (rd_word)
      `SIRR_IDX_RATE_CMD:      next_rdata = {24'h000000, rate_table_command};
      `SIRR_IDX_OP_STATUS:     next_rdata = {31'h0, op_pending};
      `SIRR_IDX_WRITE_VALUE:   next_rdata = {16'h0000, rate_table_write_value};
      `SIRR_IDX_READ_VALUE:    next_rdata = {16'h0000, rate_table_read_value};
      `SIRR_IDX_PORT0_DROPPED: next_rdata = dropped_count[0];
      `SIRR_IDX_PORT1_DROPPED: next_rdata = dropped_count[1];
      `SIRR_IDX_PORT2_DROPPED: next_rdata = dropped_count[2];
      `SIRR_IDX_PORT0_REMAP:   next_rdata = {8'h00, port0_priority_remap};
      default:                 next_rerr  = 1'b1;
    endcase
  end

  // Read answer register
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SIRR_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rerr ? `SIRR_RESP_SLVERR : `SIRR_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Port 0 priority regeneration; the queue follows the remapped value
  wire [2:0] remapped =
    port0_priority_remap[rx_priority*`SIRR_REMAP_FIELD_WIDTH +: `SIRR_REMAP_FIELD_WIDTH];
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      queue_valid    <= 1'b0;
      regen_priority <= 3'h0;
      queue_select   <= 2'h0;
    end else begin
      queue_valid <= rx_frame_valid;
      if (rx_frame_valid) begin
        regen_priority <= remapped;
        queue_select   <= remapped[2:1];
      end
    end
  end

endmodule // sirr_top

// ### verif/sirr_monitor.sv
// Port assertions for the ingress register group
`timescale 1ns/1ps
`include "sirr_regs.vh"
module sirr_monitor #(
  parameter AW = 16
) (
  // Clock and reset
  input wire          clk_sys,
  input wire          reset_n,
  // Bus handshakes
  input wire          s_axi_awvalid,
  input wire          s_axi_awready,
  input wire          s_axi_wvalid,
  input wire          s_axi_wready,
  input wire          s_axi_bvalid,
  input wire          s_axi_bready,
  input wire          s_axi_arvalid,
  input wire          s_axi_arready,
  input wire [AW-1:0] s_axi_araddr,
  input wire          s_axi_rvalid,
  input wire          s_axi_rready,
  input wire [31:0]   s_axi_rdata,
  input wire [1:0]    s_axi_rresp,
  // Priority and meter side
  input wire          rx_frame_valid,
  input wire          queue_valid,
  input wire [2:0]    regen_priority,
  input wire [1:0]    queue_select,
  input wire [4:0]    meter_index,
  input wire [21:0]   meter_byte_time_ns
);
  // Unmapped word the bench reads to provoke an error
  localparam [15:0] UNMAPPED = 16'h6150;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Bus transfer steps
  sequence wr_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_done;
    s_axi_rvalid && s_axi_rready;
  endsequence

  chk_write_answered: assert property (wr_both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write left unanswered");
  chk_write_closes: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_read_answered: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read left unanswered");
  chk_read_closes: assert property (rd_done |=> !s_axi_rvalid)
    else $error("read data repeated");
  chk_unmapped_error: assert property (rd_taken ##0 s_axi_araddr == UNMAPPED
    |=> s_axi_rresp == `SIRR_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_queue_pulse: assert property (queue_valid == $past(rx_frame_valid))
    else $error("queue pulse not one edge after frame");
  chk_queue_choice: assert property (queue_valid |-> queue_select == regen_priority[2:1])
    else $error("queue not taken from regenerated priority");
  chk_meter_step: assert property (meter_byte_time_ns % 22'd20 == 22'd0)
    else $error("byte time not a multiple of 20 ns");
  chk_meter_floor: assert property ($stable(meter_index)[*4] |-> meter_byte_time_ns >= 22'd20)
    else $error("byte time below one step");
endmodule // sirr_monitor

// ### verif/sirr_top_test.sv
// Directed bench for the ingress register group
`timescale 1ns/1ps
`include "sirr_regs.vh"
module sirr_top_test;
  // Byte addresses, four times each register index
  localparam logic [15:0] A_CMD = `SIRR_IDX_RATE_CMD << 2;
  localparam logic [15:0] A_STS = `SIRR_IDX_OP_STATUS << 2;
  localparam logic [15:0] A_WV  = `SIRR_IDX_WRITE_VALUE << 2;
  localparam logic [15:0] A_RV  = `SIRR_IDX_READ_VALUE << 2;
  localparam logic [15:0] A_C0  = `SIRR_IDX_PORT0_DROPPED << 2;
  localparam logic [15:0] A_RMP = `SIRR_IDX_PORT0_REMAP << 2;
  localparam logic [15:0] A_BAD = 16'h6150;
  localparam logic [1:0]  OK    = `SIRR_RESP_OKAY;
  localparam logic [1:0]  ERR   = `SIRR_RESP_SLVERR;
  // Stimulus and observed signals
  logic        clk_sys = 0, reset_n = 0;
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, rxv = 0;
  logic [15:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [2:0]  dv = 0, drl = 0, rxp = 0;
  logic [4:0]  mi = 0;
  wire         awr, wr, bv, arr, rv, qv;
  wire  [1:0]  bresp, rresp, qs;
  wire  [31:0] rd;
  wire  [2:0]  rp;
  wire  [21:0] mt;
  int          n_fail = 0, checked = 0, cycles = 0;

  sirr_top dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .drop_valid(dv), .drop_by_rate_limit(drl), .rx_frame_valid(rxv), .rx_priority(rxp),
    .queue_valid(qv), .regen_priority(rp), .queue_select(qs),
    .meter_index(mi), .meter_byte_time_ns(mt)
  );

  // 20 MHz system clock
  initial forever #25 clk_sys = ~clk_sys;
  // Cycle ceiling cuts a hung handshake short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      close_out;
    end
  end

  // Value compare shared by every scenario
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic bus_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    r = bresp;
    br <= 1'b0;
  endtask
  // Read held until accepted, data taken at the answering edge
  task automatic bus_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk_sys); while (!arr);
    arv <= 1'b0;
    do @(posedge clk_sys); while (!rv);
    d = rd;
    r = rresp;
    rr <= 1'b0;
  endtask
  task automatic wr_chk(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    bus_wr(a, d, r);
    chk({30'h0, r}, {30'h0, e});
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    bus_rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // Table command, then poll until the pending flag drops
  task automatic tbl_op(input logic [7:0] c);
    logic [31:0] s;
    logic [1:0]  r;
    int          n;
    wr_chk(A_CMD, {24'h0, c}, OK);
    n = 0;
    do begin
      bus_rd(A_STS, s, r);
      n++;
    end while (s[0] !== 1'b0 && n < 10);
    chk(s, 32'h0);
  endtask

  // Reset values, access kinds, unmapped word
  task automatic t_regs;
    for (int p = 0; p < 3; p++) rd_chk(A_C0 + 16'(4 * p), 32'h0, OK);
    rd_chk(A_STS, 32'h0, OK);
    rd_chk(A_WV, 32'h0, OK);
    wr_chk(A_WV, 32'hffffffff, OK);
    rd_chk(A_WV, 32'h0000ffff, OK);
    wr_chk(A_RV, 32'h1234, ERR);
    rd_chk(A_RV, 32'h0, OK);
    wr_chk(A_BAD, 32'h1, ERR);
    rd_chk(A_BAD, 32'h0, ERR);
    $display("t_regs done");
  endtask
  // Each entry type, the last rate index and two refused commands
  task automatic t_table;
    logic [23:0] tc [9] = '{24'h250000, 24'h400000, 24'h600000, 24'hb7a5c3, 24'hc01234,
                            24'he0beef, 24'hb87777, 24'h805555, 24'h200000};
    logic [15:0] te [9] = '{16'h0014, 16'h0600, 16'h0600, 16'ha5c3, 16'h1234,
                            16'hbeef, 16'h0000, 16'h0000, 16'h0014};
    foreach (tc[i]) begin
      if (tc[i][23]) begin
        wr_chk(A_WV, {16'h0, tc[i][15:0]}, OK);
        tbl_op({1'b0, tc[i][22:16]});
      end
      tbl_op({1'b1, tc[i][22:16]});
      rd_chk(A_RV, {16'h0, te[i]}, OK);
    end
    $display("t_table done");
  endtask
  // Stored rate turned into time per byte
  task automatic t_meter;
    logic [15:0] v [3] = '{16'h0031, 16'h0014, 16'ha5c3};
    logic [4:0]  ix [3] = '{5'd3, 5'd0, 5'd23};
    wr_chk(A_WV, 32'h31, OK);
    tbl_op(8'h23);
    rd_chk(A_CMD, 32'h23, OK);
    foreach (v[i]) begin
      @(posedge clk_sys);
      mi <= ix[i];
      repeat (3) @(posedge clk_sys);
      chk({10'h0, mt}, ({16'h0, v[i]} + 32'h1) * 32'd20);
    end
    $display("t_meter done");
  endtask
  // One-cycle drop pulse on chosen ports
  task automatic drop(input logic [2:0] v, input logic [2:0] rl);
    @(posedge clk_sys);
    dv <= v;
    drl <= rl;
    @(posedge clk_sys);
    dv <= 3'h0;
    drl <= 3'h0;
  endtask
  // Rate-limit drops must not count; a read empties the counter
  task automatic t_counters;
    logic [31:0] e [3] = '{32'h3, 32'h2, 32'h1};
    drop(3'b111, 3'b000);
    drop(3'b011, 3'b010);
    drop(3'b101, 3'b100);
    drop(3'b010, 3'b000);
    foreach (e[i]) rd_chk(A_C0 + 16'(4 * i), e[i], OK);
    foreach (e[i]) rd_chk(A_C0 + 16'(4 * i), 32'h0, OK);
    $display("t_counters done");
  endtask
  // Sampled at the falling edge, after the queue pulse has landed
  task automatic frame(input logic [2:0] p, input logic [2:0] e);
    @(posedge clk_sys);
    rxv <= 1'b1;
    rxp <= p;
    @(posedge clk_sys);
    rxv <= 1'b0;
    @(negedge clk_sys);
    chk({26'h0, qv, rp, qs}, {26'h0, 1'b1, e, e[2:1]});
  endtask
  // Identity map after reset, then a reversed map
  task automatic t_remap;
    logic [23:0] m;
    for (int i = 0; i < 8; i++) m[3*i +: 3] = 3'(i);
    rd_chk(A_RMP, {8'h0, m}, OK);
    for (int i = 0; i < 8; i++) frame(3'(i), 3'(i));
    for (int i = 0; i < 8; i++) m[3*i +: 3] = 3'(7 - i);
    wr_chk(A_RMP, {8'hff, m}, OK);
    rd_chk(A_RMP, {8'h0, m}, OK);
    for (int i = 0; i < 8; i++) frame(3'(i), 3'(7 - i));
    $display("t_remap done");
  endtask

  task automatic close_out;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Reset for six cycles, then the scenarios in order
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs;
    t_table;
    t_meter;
    t_counters;
    t_remap;
    close_out;
  end
endmodule // sirr_top_test

bind sirr_top sirr_monitor #(.AW(AW)) mon_u (
  .clk_sys(clk_sys), .reset_n(reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .rx_frame_valid(rx_frame_valid), .queue_valid(queue_valid),
  .regen_priority(regen_priority), .queue_select(queue_select),
  .meter_index(meter_index), .meter_byte_time_ns(meter_byte_time_ns)
);
